//--- common/irq_rx_consts.svh
`ifndef IRQ_RX_CONSTS_SVH
`define IRQ_RX_CONSTS_SVH

// register offsets
`define ADDR_EVENT_ENABLE_TWO 8'h04
`define ADDR_EVENT_FLAGS_TWO 8'h06
`define ADDR_ROUTE_GROUP_ONE 8'h07
`define ADDR_ROUTE_GROUP_TWO 8'h08
`define ADDR_PIN_CFG 8'h09
`define ADDR_DELAY_LOOP_CTRL 8'h0a
`define ADDR_WARN_CLEAR_CTRL 8'h0b
`define ADDR_RESERVED_TUNING 8'h0c
`define ADDR_CLOCK_RATE_MODE 8'h0d
`define ADDR_RX_STATUS 8'h0e

// reset values
`define RST_EVENT_ENABLE_TWO 8'h00
`define RST_EVENT_FLAGS_TWO 8'h00
`define RST_ROUTE_GROUP_ONE 8'h00
`define RST_ROUTE_GROUP_TWO 8'h00
`define RST_PIN_CFG 8'h00
`define RST_DELAY_LOOP_CTRL 8'h40
`define RST_WARN_CLEAR_CTRL 8'h39
`define RST_RESERVED_TUNING 8'h64
`define RST_CLOCK_RATE_MODE 8'h06

// writable bit masks
`define MASK_FLAGS_TWO 8'hf7
`define MASK_ROUTE_GROUP_ONE 8'h7f
`define MASK_PIN_CFG 8'h33
`define MASK_DELAY_LOOP_CTRL 8'hcf

// second flag group bit positions
`define BIT_PARITY_FAIL 7
`define BIT_SAMPLE_FAIL 6
`define BIT_DLL_WARNING 5
`define BIT_DLL_LOCKED 4
`define BIT_FIFO_UNDERFLOW 2
`define BIT_FIFO_OVERFLOW 1
`define BIT_FIFO_WARNING 0

// configuration fields
`define BIT_PARITY_IN_USE 5
`define BIT_FRAMING_IN_USE 4
`define BIT_DLL_ENABLE 7
`define BIT_DUTY_CORRECTION 6
`define BIT_CLEAR_WARN 7
`define BIT_SLOW_DATA_CLOCK 7
`define BIT_FIXED_DELAY_LINE 4

// status fields
`define BIT_STAT_LOCK 7
`define BIT_STAT_WARN 6
`define BIT_STAT_START_WARN 5
`define BIT_STAT_END_WARN 4
`define BIT_STAT_CLOCK_ON 2
`define BIT_STAT_RUNNING 0

// locked phase in 11.25 degree steps: 90 degrees is 8 steps
`define PHASE_BASE_STEPS 5'd8
`define PHASE_MAX_MAG 3'd6

// fifo warning distance from either end, in slots
`define FIFO_WARN_MARGIN 1

`endif

//--- common/rx_cfg_pkg.sv
package rx_cfg_pkg;

  typedef enum logic [1:0] {
    ROLE_NONE = 2'h0,
    ROLE_PARITY = 2'h1,
    ROLE_FRAME = 2'h2,
    ROLE_RESERVED = 2'h3
  } shared_pin_role_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

  typedef struct packed {
    logic parity_mismatch;
    logic sample_mismatch;
    logic dll_warning;
    logic dll_locked;
    logic dll_start_warn;
    logic dll_end_warn;
    logic data_clock_on;
  } rx_event_type;

  typedef struct packed {
    logic dll_enable;
    logic duty_correction;
    logic [4:0] lock_phase_steps;
    logic phase_offset_valid;
    shared_pin_role_type shared_pin_role;
    logic parity_in_use;
    logic framing_in_use;
    logic slow_data_clock_mode;
    logic fixed_delay_line_mode;
    logic [7:0] reserved_tuning;
  } rx_cfg_type;

endpackage : rx_cfg_pkg

//--- logic/sticky_flag_bank.sv
`timescale 1ns/1ps
`default_nettype none

module sticky_flag_bank #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] IMPL_MASK = '1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // set and clear
  input wire logic [WIDTH-1:0] set_in,
  input wire logic [WIDTH-1:0] clear_in,
  // state
  output logic [WIDTH-1:0] flags_out
);

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("sticky_flag_bank needs at least one flag");
    end
  endgenerate

  logic [WIDTH-1:0] flags_ff;

  // set wins over clear so an event in the clearing cycle is kept
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_flag
      if (IMPL_MASK[i]) begin : g_impl
        always_ff @(posedge clk_in or negedge rst_n_in) begin
          if (!rst_n_in) begin
            flags_ff[i] <= RESET_VALUE[i];
          end else if (set_in[i]) begin
            flags_ff[i] <= 1'b1;
          end else if (clear_in[i]) begin
            flags_ff[i] <= 1'b0;
          end
        end
      end else begin : g_unused
        assign flags_ff[i] = 1'b0;
      end
    end
  endgenerate

  assign flags_out = flags_ff;

endmodule : sticky_flag_bank

`default_nettype wire

//--- logic/fifo_event_monitor.sv
`timescale 1ns/1ps
`default_nettype none

`include "irq_rx_consts.svh"

module fifo_event_monitor #(
  parameter int PTR_WIDTH = 3
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // fifo pointers
  input wire logic [PTR_WIDTH-1:0] wr_ptr_in,
  input wire logic [PTR_WIDTH-1:0] rd_ptr_in,
  // events
  output logic underflow_out,
  output logic overflow_out,
  output logic warning_out
);

  localparam int DEPTH = 1 << PTR_WIDTH;
  localparam logic [PTR_WIDTH-1:0] LOW_MARK = PTR_WIDTH'(`FIFO_WARN_MARGIN);
  localparam logic [PTR_WIDTH-1:0] HIGH_MARK = PTR_WIDTH'(DEPTH - 1 - `FIFO_WARN_MARGIN);

  generate
    if (PTR_WIDTH < 3) begin : g_bad_ptr
      $error("fifo_event_monitor needs at least eight slots");
    end
  endgenerate

  logic [PTR_WIDTH-1:0] prev_wr_ff;
  logic [PTR_WIDTH-1:0] prev_rd_ff;
  logic [PTR_WIDTH-1:0] occupancy;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prev_wr_ff <= '0;
      prev_rd_ff <= '0;
    end else begin
      prev_wr_ff <= wr_ptr_in;
      prev_rd_ff <= rd_ptr_in;
    end
  end

  // equal pointers are ambiguous, so the mover decides: reader moving onto the writer
  // is underflow, writer moving onto the reader is overflow
  assign occupancy = wr_ptr_in - rd_ptr_in;
  assign underflow_out = (rd_ptr_in != prev_rd_ff) && (rd_ptr_in == wr_ptr_in); // see RQ4
  assign overflow_out = (wr_ptr_in != prev_wr_ff) && (wr_ptr_in == rd_ptr_in); // see RQ5
  assign warning_out = (occupancy <= LOW_MARK) || (occupancy >= HIGH_MARK); // see RQ6

  property p_fifo_warning;
    @(posedge clk_in) disable iff (!rst_n_in)
    ((wr_ptr_in - rd_ptr_in) == PTR_WIDTH'(DEPTH - 2)) |-> warning_out;
  endproperty
  a_fifo_warning: assert property (p_fifo_warning) // see RQ6
    else $error("fifo warning missing at one slot from full");

  property p_fifo_quiet;
    @(posedge clk_in) disable iff (!rst_n_in)
    ((wr_ptr_in - rd_ptr_in) == PTR_WIDTH'(DEPTH - 3)) |-> !warning_out;
  endproperty
  a_fifo_quiet: assert property (p_fifo_quiet) // see RQ6
    else $error("fifo warning raised two slots from full");

endmodule : fifo_event_monitor

`default_nettype wire

//--- logic/irq_route_and_data_rx_cfg.sv
`timescale 1ns/1ps
`default_nettype none

`include "irq_rx_consts.svh"

// Contract
// RQ1: parity mismatch sets flag bit 7 of second flag register.
// RQ2: sample comparison mismatch sets flag bit 6.
// RQ3: delay loop warning sets bit 5; delay loop lock sets bit 4.
// RQ4: read pointer reaching write pointer sets underflow bit 2.
// RQ5: pointer collision on write sets overflow bit 1.
// RQ6: occupancy at most one or at least six sets warning bit 0.
// RQ7: first group events go to pin a on select 0, pin b on 1.
// RQ8: second group events go to pin b on select 1, else pin a.
// RQ9: software sets parity usage bit 5 when parity checking is used.
// RQ10: software sets framing usage bit 4 when frame input is used.
// RQ11: pin role field: 0 none, 1 parity, 2 frame, 3 reserved.
// RQ12: control bit 7 enables delay loop; bit 6 duty correction, reset on.
// RQ13: lock phase 90 plus n times 11.25, n sign-magnitude, -6 to +6.
// RQ14: writing 1 to clear bit clears receiver warning status bits.
// RQ15: software writes only default values into reserved fields.
// RQ16: software clears slow clock bit at 350 MHz or more, else sets.
// RQ17: software clears fixed line bit in loop mode, sets it otherwise.
// RQ18: loop mode preferred above 250 MHz, fixed line below; advice only.
// RQ19: each second group flag has an enable bit, reset zero.
// RQ20: status bit 6 warns near either line end; start, end bits below.
// RQ21: a pin is high while any set, enabled flag routed to it stays set.
module irq_route_and_data_rx_cfg
  import rx_cfg_pkg::*;
#(
  parameter int PTR_WIDTH = 3
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // register port from the serial control decoder
  input wire reg_req_type reg_req_in,
  output logic [7:0] reg_rdata_out,
  // receiver events
  input wire rx_event_type rx_event_in,
  input wire logic [PTR_WIDTH-1:0] fifo_wr_ptr_in,
  input wire logic [PTR_WIDTH-1:0] fifo_rd_ptr_in,
  // first group, already enabled
  input wire logic [6:0] group_one_pending_in,
  // interrupt pins
  output logic interrupt_pin_a_out,
  output logic interrupt_pin_b_out,
  // receiver configuration
  output rx_cfg_type rx_cfg_out,
  output logic parity_check_en_out,
  output logic frame_check_en_out
);

  generate
    if (PTR_WIDTH < 3) begin : g_bad_ptr
      $error("fifo pointers need at least three bits");
    end
  endgenerate

  function automatic logic is_writable(input logic [7:0] addr);
    is_writable = (addr == `ADDR_EVENT_ENABLE_TWO) || (addr == `ADDR_EVENT_FLAGS_TWO) ||
                  ((addr >= `ADDR_ROUTE_GROUP_ONE) && (addr <= `ADDR_CLOCK_RATE_MODE));
  endfunction : is_writable

  function automatic logic hit(input reg_req_type req, input logic [7:0] addr);
    hit = req.wr && is_writable(req.addr) && (req.addr == addr);
  endfunction : hit

  // reset release through two flops
  logic rst_meta_ff;
  logic rst_sync_ff;
  logic rst_n;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  assign rst_n = rst_sync_ff;

  logic [7:0] enable_two_ff;
  logic [7:0] route_one_ff;
  logic [7:0] route_two_ff;
  logic [7:0] pin_cfg_ff;
  logic [7:0] loop_ctrl_ff;
  logic [7:0] warn_ctrl_ff;
  logic [7:0] tuning_ff;
  logic [7:0] rate_mode_ff;

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      enable_two_ff <= `RST_EVENT_ENABLE_TWO; // see RQ19
      route_one_ff <= `RST_ROUTE_GROUP_ONE;
      route_two_ff <= `RST_ROUTE_GROUP_TWO;
      pin_cfg_ff <= `RST_PIN_CFG;
      loop_ctrl_ff <= `RST_DELAY_LOOP_CTRL; // see RQ12
      warn_ctrl_ff <= `RST_WARN_CLEAR_CTRL;
      tuning_ff <= `RST_RESERVED_TUNING;
      rate_mode_ff <= `RST_CLOCK_RATE_MODE;
    end else begin
      if (hit(reg_req_in, `ADDR_EVENT_ENABLE_TWO)) begin
        enable_two_ff <= reg_req_in.wdata & `MASK_FLAGS_TWO; // see RQ19
      end
      if (hit(reg_req_in, `ADDR_ROUTE_GROUP_ONE)) begin
        route_one_ff <= reg_req_in.wdata & `MASK_ROUTE_GROUP_ONE;
      end
      if (hit(reg_req_in, `ADDR_ROUTE_GROUP_TWO)) begin
        route_two_ff <= reg_req_in.wdata & `MASK_FLAGS_TWO;
      end
      if (hit(reg_req_in, `ADDR_PIN_CFG)) begin
        pin_cfg_ff <= reg_req_in.wdata & `MASK_PIN_CFG;
      end
      if (hit(reg_req_in, `ADDR_DELAY_LOOP_CTRL)) begin
        loop_ctrl_ff <= reg_req_in.wdata & `MASK_DELAY_LOOP_CTRL;
      end
      if (hit(reg_req_in, `ADDR_WARN_CLEAR_CTRL)) begin
        warn_ctrl_ff <= reg_req_in.wdata;
      end
      if (hit(reg_req_in, `ADDR_RESERVED_TUNING)) begin
        tuning_ff <= reg_req_in.wdata;
      end
      if (hit(reg_req_in, `ADDR_CLOCK_RATE_MODE)) begin
        rate_mode_ff <= reg_req_in.wdata;
      end
    end
  end

  // second flag group
  logic fifo_underflow;
  logic fifo_overflow;
  logic fifo_warning;
  logic [7:0] flag_set;
  logic [7:0] flag_clear;
  logic [7:0] flags_two;

  fifo_event_monitor #(
    .PTR_WIDTH(PTR_WIDTH)
  ) u_fifo_mon (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .wr_ptr_in(fifo_wr_ptr_in),
    .rd_ptr_in(fifo_rd_ptr_in),
    .underflow_out(fifo_underflow),
    .overflow_out(fifo_overflow),
    .warning_out(fifo_warning)
  );

  always_comb begin
    flag_set = 8'h00;
    flag_set[`BIT_PARITY_FAIL] = rx_event_in.parity_mismatch; // see RQ1
    flag_set[`BIT_SAMPLE_FAIL] = rx_event_in.sample_mismatch; // see RQ2
    flag_set[`BIT_DLL_WARNING] = rx_event_in.dll_warning; // see RQ3
    flag_set[`BIT_DLL_LOCKED] = rx_event_in.dll_locked; // see RQ3
    flag_set[`BIT_FIFO_UNDERFLOW] = fifo_underflow; // see RQ4
    flag_set[`BIT_FIFO_OVERFLOW] = fifo_overflow; // see RQ5
    flag_set[`BIT_FIFO_WARNING] = fifo_warning; // see RQ6
  end

  // write one to clear; a level event that stays high simply sets again
  assign flag_clear = hit(reg_req_in, `ADDR_EVENT_FLAGS_TWO) ? reg_req_in.wdata : 8'h00;

  sticky_flag_bank #(
    .WIDTH(8),
    .IMPL_MASK(`MASK_FLAGS_TWO),
    .RESET_VALUE(`RST_EVENT_FLAGS_TWO)
  ) u_flags_two (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .set_in(flag_set),
    .clear_in(flag_clear),
    .flags_out(flags_two)
  );

  // receiver warning status, cleared by the clear bit
  logic clear_warn;
  logic [1:0] line_warn;

  assign clear_warn = hit(reg_req_in, `ADDR_WARN_CLEAR_CTRL) && reg_req_in.wdata[`BIT_CLEAR_WARN];

  sticky_flag_bank #(
    .WIDTH(2),
    .IMPL_MASK(2'h3),
    .RESET_VALUE(2'h0)
  ) u_line_warn (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .set_in({rx_event_in.dll_start_warn, rx_event_in.dll_end_warn}), // see RQ20
    .clear_in({2{clear_warn}}), // see RQ14
    .flags_out(line_warn)
  );

  logic [7:0] rx_status;
  always_comb begin
    rx_status = 8'h00;
    rx_status[`BIT_STAT_LOCK] = rx_event_in.dll_locked;
    rx_status[`BIT_STAT_WARN] = |line_warn; // see RQ20
    rx_status[`BIT_STAT_START_WARN] = line_warn[1];
    rx_status[`BIT_STAT_END_WARN] = line_warn[0];
    rx_status[`BIT_STAT_CLOCK_ON] = rx_event_in.data_clock_on;
    rx_status[`BIT_STAT_RUNNING] = loop_ctrl_ff[`BIT_DLL_ENABLE];
  end

  // interrupt routing; pins registered to keep them glitch free
  logic [7:0] pending_two;
  logic nxt_pin_a;
  logic nxt_pin_b;
  logic pin_a_ff;
  logic pin_b_ff;

  assign pending_two = flags_two & enable_two_ff;
  assign nxt_pin_a = |(group_one_pending_in & ~route_one_ff[6:0]) | // see RQ7
                     |(pending_two & ~route_two_ff); // see RQ8
  assign nxt_pin_b = |(group_one_pending_in & route_one_ff[6:0]) | // see RQ7
                     |(pending_two & route_two_ff); // see RQ8

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pin_a_ff <= 1'b0;
      pin_b_ff <= 1'b0;
    end else begin
      pin_a_ff <= nxt_pin_a; // see RQ21
      pin_b_ff <= nxt_pin_b; // see RQ21
    end
  end
  assign interrupt_pin_a_out = pin_a_ff;
  assign interrupt_pin_b_out = pin_b_ff;

  // lock phase in 11.25 degree steps; out-of-range magnitudes clamp to six steps
  logic [2:0] phase_mag;
  logic phase_valid;
  logic [4:0] phase_steps;
  assign phase_valid = (loop_ctrl_ff[2:0] <= `PHASE_MAX_MAG); // see RQ13
  assign phase_mag = phase_valid ? loop_ctrl_ff[2:0] : `PHASE_MAX_MAG;
  assign phase_steps = loop_ctrl_ff[3] ? (`PHASE_BASE_STEPS - {2'b00, phase_mag})
                                       : (`PHASE_BASE_STEPS + {2'b00, phase_mag}); // see RQ13

  shared_pin_role_type role;
  assign role = shared_pin_role_type'(pin_cfg_ff[1:0]);

  rx_cfg_type cfg_ff;
  logic parity_en_ff;
  logic frame_en_ff;

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff <= '0;
      parity_en_ff <= 1'b0;
      frame_en_ff <= 1'b0;
    end else begin
      cfg_ff.dll_enable <= loop_ctrl_ff[`BIT_DLL_ENABLE]; // see RQ12
      cfg_ff.duty_correction <= loop_ctrl_ff[`BIT_DUTY_CORRECTION]; // see RQ12
      cfg_ff.lock_phase_steps <= phase_steps;
      cfg_ff.phase_offset_valid <= phase_valid;
      cfg_ff.shared_pin_role <= role;
      cfg_ff.parity_in_use <= pin_cfg_ff[`BIT_PARITY_IN_USE];
      cfg_ff.framing_in_use <= pin_cfg_ff[`BIT_FRAMING_IN_USE];
      cfg_ff.slow_data_clock_mode <= rate_mode_ff[`BIT_SLOW_DATA_CLOCK];
      cfg_ff.fixed_delay_line_mode <= rate_mode_ff[`BIT_FIXED_DELAY_LINE];
      cfg_ff.reserved_tuning <= tuning_ff;
      // reserved role drives neither checker
      parity_en_ff <= (role == ROLE_PARITY); // see RQ11
      frame_en_ff <= (role == ROLE_FRAME); // see RQ11
    end
  end
  assign rx_cfg_out = cfg_ff;
  assign parity_check_en_out = parity_en_ff;
  assign frame_check_en_out = frame_en_ff;

  // read data one cycle after the read strobe; unmapped reads return zero
  logic [7:0] rdata_ff;
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else if (reg_req_in.rd) begin
      if (reg_req_in.addr == `ADDR_EVENT_ENABLE_TWO) begin
        rdata_ff <= enable_two_ff;
      end else if (reg_req_in.addr == `ADDR_EVENT_FLAGS_TWO) begin
        rdata_ff <= flags_two;
      end else if (reg_req_in.addr == `ADDR_ROUTE_GROUP_ONE) begin
        rdata_ff <= route_one_ff;
      end else if (reg_req_in.addr == `ADDR_ROUTE_GROUP_TWO) begin
        rdata_ff <= route_two_ff;
      end else if (reg_req_in.addr == `ADDR_PIN_CFG) begin
        rdata_ff <= pin_cfg_ff;
      end else if (reg_req_in.addr == `ADDR_DELAY_LOOP_CTRL) begin
        rdata_ff <= loop_ctrl_ff;
      end else if (reg_req_in.addr == `ADDR_WARN_CLEAR_CTRL) begin
        rdata_ff <= warn_ctrl_ff;
      end else if (reg_req_in.addr == `ADDR_RESERVED_TUNING) begin
        rdata_ff <= tuning_ff;
      end else if (reg_req_in.addr == `ADDR_CLOCK_RATE_MODE) begin
        rdata_ff <= rate_mode_ff;
      end else if (reg_req_in.addr == `ADDR_RX_STATUS) begin
        rdata_ff <= rx_status;
      end else begin
        rdata_ff <= 8'h00;
      end
    end
  end
  assign reg_rdata_out = rdata_ff;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n);

  property p_parity_flag;
    rx_event_in.parity_mismatch |=> flags_two[`BIT_PARITY_FAIL];
  endproperty
  a_parity_flag: assert property (p_parity_flag) // see RQ1
    else $error("parity flag not set after mismatch");

  property p_sample_flag;
    rx_event_in.sample_mismatch |=> flags_two[`BIT_SAMPLE_FAIL];
  endproperty
  a_sample_flag: assert property (p_sample_flag) // see RQ2
    else $error("sample check flag not set after mismatch");

  property p_dll_flags;
    (rx_event_in.dll_warning && rx_event_in.dll_locked) |=> (flags_two[5:4] == 2'b11);
  endproperty
  a_dll_flags: assert property (p_dll_flags) // see RQ3
    else $error("delay loop flags not both set");

  property p_underflow;
    ((fifo_rd_ptr_in != $past(fifo_rd_ptr_in)) && (fifo_rd_ptr_in == fifo_wr_ptr_in))
      |=> flags_two[`BIT_FIFO_UNDERFLOW];
  endproperty
  a_underflow: assert property (p_underflow) // see RQ4
    else $error("underflow flag missing");

  property p_overflow;
    fifo_overflow |=> flags_two[`BIT_FIFO_OVERFLOW] && !flags_two[3];
  endproperty
  a_overflow: assert property (p_overflow) // see RQ5
    else $error("overflow flag missing");

  property p_route_one;
    (|(group_one_pending_in & ~route_one_ff[6:0])) |=> interrupt_pin_a_out;
  endproperty
  a_route_one: assert property (p_route_one) // see RQ7
    else $error("first group event not on pin a");

  property p_route_two;
    (|(flags_two & enable_two_ff & route_two_ff)) |=> interrupt_pin_b_out;
  endproperty
  a_route_two: assert property (p_route_two) // see RQ8
    else $error("second group event not on pin b");

  property p_pins_quiet;
    ((group_one_pending_in == 7'h00) && (pending_two == 8'h00))
      |=> !interrupt_pin_a_out && !interrupt_pin_b_out;
  endproperty
  a_pins_quiet: assert property (p_pins_quiet) // see RQ21
    else $error("interrupt pin high with nothing pending");

  property p_role;
    hit(reg_req_in, `ADDR_PIN_CFG) |=> ##1
      (parity_check_en_out == ($past(reg_req_in.wdata[1:0], 2) == 2'h1)) &&
      (frame_check_en_out == ($past(reg_req_in.wdata[1:0], 2) == 2'h2));
  endproperty
  a_role: assert property (p_role) // see RQ11
    else $error("shared pin role decode wrong");

  property p_loop_enable;
    hit(reg_req_in, `ADDR_DELAY_LOOP_CTRL) |=> ##1
      (rx_cfg_out.dll_enable == $past(reg_req_in.wdata[7], 2)) &&
      (rx_cfg_out.duty_correction == $past(reg_req_in.wdata[6], 2));
  endproperty
  a_loop_enable: assert property (p_loop_enable) // see RQ12
    else $error("delay loop or duty correction enable wrong");

  property p_phase_range;
    (phase_steps >= 5'd2) && (phase_steps <= 5'd14);
  endproperty
  a_phase_range: assert property (p_phase_range) // see RQ13
    else $error("lock phase outside thirteen steps");

  property p_warn_clear;
    (clear_warn && !rx_event_in.dll_start_warn && !rx_event_in.dll_end_warn)
      |=> (line_warn == 2'b00) && !rx_status[`BIT_STAT_WARN];
  endproperty
  a_warn_clear: assert property (p_warn_clear) // see RQ14
    else $error("receiver warnings not cleared");

  property p_enable_write;
    hit(reg_req_in, `ADDR_EVENT_ENABLE_TWO) |=> (enable_two_ff == ($past(reg_req_in.wdata) & 8'hf7));
  endproperty
  a_enable_write: assert property (p_enable_write) // see RQ19
    else $error("event enable register not updated");

  property p_line_warn;
    rx_event_in.dll_end_warn |=> rx_status[`BIT_STAT_WARN] && rx_status[`BIT_STAT_END_WARN];
  endproperty
  a_line_warn: assert property (p_line_warn) // see RQ20
    else $error("line end warning not reported");

  c_pin_a: cover property (!interrupt_pin_a_out ##1 interrupt_pin_a_out);
  c_pin_b: cover property (!interrupt_pin_b_out ##1 interrupt_pin_b_out);
  c_flag_clear: cover property (flags_two[7] ##1 hit(reg_req_in, `ADDR_EVENT_FLAGS_TWO) ##1 !flags_two[7]);
  c_warn_clear: cover property (line_warn != 2'b00 ##1 clear_warn ##1 line_warn == 2'b00);

endmodule : irq_route_and_data_rx_cfg

`default_nettype wire

//--- sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import rx_cfg_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  reg_req_type reg_req_in = '0;
  rx_event_type rx_event_in = '0;
  logic [2:0] fifo_wr_ptr_in = 3'h3;
  logic [2:0] fifo_rd_ptr_in = 3'h0;
  logic [6:0] group_one_pending_in = 7'h00;
  logic [7:0] reg_rdata_out;
  logic interrupt_pin_a_out;
  logic interrupt_pin_b_out;
  rx_cfg_type rx_cfg_out;
  logic parity_check_en_out;
  logic frame_check_en_out;
  int fails = 0;
  int n_checks = 0;
  logic [7:0] rst_addr [9] = '{8'h04, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d};
  logic [7:0] rst_val [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h39, 8'h64, 8'h06};
  logic [7:0] ph_wr [4] = '{8'h86, 8'h4e, 8'h40, 8'h07};
  logic [7:0] ph_steps [4] = '{8'h0e, 8'h02, 8'h08, 8'h0e};
  logic ph_ok [4] = '{1'b1, 1'b1, 1'b1, 1'b0};

  irq_route_and_data_rx_cfg #(.PTR_WIDTH(3)) dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .reg_req_in(reg_req_in), .reg_rdata_out(reg_rdata_out), .rx_event_in(rx_event_in),
    .fifo_wr_ptr_in(fifo_wr_ptr_in), .fifo_rd_ptr_in(fifo_rd_ptr_in),
    .group_one_pending_in(group_one_pending_in), .interrupt_pin_a_out(interrupt_pin_a_out),
    .interrupt_pin_b_out(interrupt_pin_b_out), .rx_cfg_out(rx_cfg_out),
    .parity_check_en_out(parity_check_en_out), .frame_check_en_out(frame_check_en_out));

  always #12.5 clk_in = ~clk_in;

  // inputs move 2 ns after the rising edge so no edge sees a half-changed request
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #2;
  endtask : tick

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_req_in = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    tick(1);
    reg_req_in = '0;
    tick(1);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_req_in = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    tick(1);
    reg_req_in = '0;
    check("reg", reg_rdata_out, exp);
    tick(1);
  endtask : rd

  task automatic pins(input logic a, input logic b);
    tick(2);
    check("pins", {6'h00, interrupt_pin_a_out, interrupt_pin_b_out}, {6'h00, a, b});
  endtask : pins

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    tick(5);
    rst_n_in = 1'b1;
    tick(4);
    for (int i = 0; i < 9; i++) rd(rst_addr[i], rst_val[i]);
    check("duty", {7'h00, rx_cfg_out.duty_correction}, 8'h01);
    check("steps", {3'h0, rx_cfg_out.lock_phase_steps}, 8'h08);
    rd(8'h20, 8'h00);
    wr(8'h04, 8'hff);
    rd(8'h04, 8'hf7);
    wr(8'h08, 8'h50);
    // events on flag bits 7 to 4; bits 6 and 4 routed to pin b
    for (int k = 0; k < 4; k++) begin
      rx_event_in = rx_event_type'(7'h40 >> k);
      tick(1);
      rx_event_in = '0;
      tick(1);
      rd(8'h06, 8'h80 >> k);
      pins(k[0] == 1'b0, k[0] == 1'b1);
      wr(8'h06, 8'h80 >> k);
      pins(1'b0, 1'b0);
    end
    fifo_rd_ptr_in = 3'h3;
    tick(2);
    rd(8'h06, 8'h05);
    pins(1'b1, 1'b0);
    fifo_wr_ptr_in = 3'h0;
    wr(8'h06, 8'h07);
    tick(1);
    rd(8'h06, 8'h00);
    fifo_wr_ptr_in = 3'h3;
    tick(2);
    rd(8'h06, 8'h03);
    fifo_wr_ptr_in = 3'h1;
    wr(8'h06, 8'h07);
    tick(1);
    rd(8'h06, 8'h01);
    fifo_wr_ptr_in = 3'h6;
    wr(8'h04, 8'h00);
    wr(8'h06, 8'h07);
    // first group routing by select bit
    group_one_pending_in = 7'h01;
    pins(1'b1, 1'b0);
    wr(8'h07, 8'hff);
    rd(8'h07, 8'h7f);
    pins(1'b0, 1'b1);
    group_one_pending_in = 7'h00;
    pins(1'b0, 1'b0);
    for (int r = 0; r < 4; r++) begin
      wr(8'h09, 8'hfc | r[7:0]);
      tick(2);
      check("role", {2'h0, rx_cfg_out.shared_pin_role, parity_check_en_out, frame_check_en_out,
        rx_cfg_out.parity_in_use, rx_cfg_out.framing_in_use},
        {2'h0, r[1:0], r == 1, r == 2, 2'b11});
    end
    rd(8'h09, 8'hff & 8'h33);
    for (int i = 0; i < 4; i++) begin
      wr(8'h0a, ph_wr[i]);
      tick(2);
      check("steps", {3'h0, rx_cfg_out.lock_phase_steps}, ph_steps[i]);
      check("ctrl", {5'h00, rx_cfg_out.duty_correction, rx_cfg_out.dll_enable,
        rx_cfg_out.phase_offset_valid}, {5'h00, ph_wr[i][6], ph_wr[i][7], ph_ok[i]});
    end
    rd(8'h0a, 8'h07);
    wr(8'h0a, 8'h40);
    rx_event_in = rx_event_type'(7'h04);
    tick(1);
    rx_event_in = '0;
    tick(2);
    rd(8'h0e, 8'h60);
    wr(8'h0b, 8'hb9);
    tick(1);
    rd(8'h0e, 8'h00);
    rd(8'h0b, 8'hb9);
    // lock and data clock bits are live, not sticky
    rx_event_in = rx_event_type'(7'h09);
    rd(8'h0e, 8'h84);
    rx_event_in = '0;
    // loop off, fixed delay line on, reserved nibble left at its default
    wr(8'h0d, 8'h16);
    tick(1);
    check("rate", {6'h00, rx_cfg_out.slow_data_clock_mode, rx_cfg_out.fixed_delay_line_mode},
      8'h01);
    check("tuning", rx_cfg_out.reserved_tuning, 8'h64);
    rd(8'h0d, 8'h16);
    complete_run();
  end
endmodule : testbench

`default_nettype wire
